/* File: rtl/mcs_map.vh */
// Register map, field layout and reset values of the current scale block
`ifndef MCS_MAP_VH
`define MCS_MAP_VH
`define MCS_ADDR_CSC        7'h55
`define MCS_RUN_SCALE_LSB   0
`define MCS_RUN_SCALE_MSB   4
`define MCS_RUN_DECAY_BIT   7
`define MCS_HOLD_SCALE_LSB  8
`define MCS_HOLD_SCALE_MSB  12
`define MCS_HOLD_DECAY_BIT  15
`define MCS_RUN_SCALE_RST   5'h10
`define MCS_HOLD_SCALE_RST  5'h00
`define MCS_RUN_DECAY_RST   1'b1
`define MCS_HOLD_DECAY_RST  1'b0
`define MCS_SCALE_FULL      5'h10
`endif

/* File: rtl/mcs_current_scale.v */
// Current scaling and standby switchover for the microstep sequencer output
`include "mcs_map.vh"

module mcs_current_scale (
    input  wire        clk,
    input  wire        rst,
    input  wire        reg_wr,
    input  wire [6:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    input  wire [19:0] hold_delay,
    input  wire        motor_moving,
    input  wire        motor_is_stepper,
    input  wire        entry_valid,
    input  wire [11:0] entry_a,
    input  wire [11:0] entry_b,
    output reg  [11:0] scaled_a_ff,
    output reg  [11:0] scaled_b_ff,
    output reg         scaled_valid_ff,
    output reg         drive_enable_ff,
    output reg         mixed_decay_ff,
    output reg         in_hold_ff
);

    // Standstill tracking states
    localparam [1:0] ST_RUN  = 2'b00;
    localparam [1:0] ST_WAIT = 2'b01;
    localparam [1:0] ST_HOLD = 2'b10;

    // Two sine channels, one scaling path each, both using the active scale
    localparam       NCHAN   = 2;
    localparam       EW      = 12;

    reg  [4:0]  run_current_scale_ff;
    reg         run_mixed_decay_en_ff;
    reg  [4:0]  hold_current_scale_ff;
    reg         hold_mixed_decay_en_ff;
    reg  [1:0]  state_ff;
    reg  [1:0]  nxt_state;
    reg  [19:0] still_cnt_ff;
    reg  [19:0] nxt_still_cnt;
    reg         nxt_in_hold;
    reg  [4:0]  nxt_run_scale;
    reg         nxt_run_decay;
    reg  [4:0]  nxt_hold_scale;
    reg         nxt_hold_decay;
    reg         nxt_drive_enable;
    reg         nxt_mixed_decay;
    wire        csc_sel;
    wire [4:0]  act_scale;
    wire        act_decay;
    wire [23:0] entry_bus;
    wire [23:0] nxt_scaled_bus;
    genvar      ch;

    // Clamp to the legal range so a stray 17..31 cannot overflow the product
    function [4:0] clamp_scale;
        input [4:0] v;
        begin
            clamp_scale = (v > `MCS_SCALE_FULL) ? `MCS_SCALE_FULL : v;
        end
    endfunction

    // Entry * scale / 16; full scale passes unchanged
    function [11:0] scale_entry;
        input [11:0] e;
        input [4:0]  s;
        reg   [16:0] prod;
        begin
            prod        = e * s;
            scale_entry = prod[15:4];
        end
    endfunction

    // Address decode of the settings register
    function addr_hit;
        input       wr;
        input [6:0] a;
        begin
            addr_hit = wr && (a == `MCS_ADDR_CSC);
        end
    endfunction

    // Run or hold setting as one word: decay above scale
    function [5:0] pick_setting;
        input       hold;
        input [4:0] run_s;
        input       run_d;
        input [4:0] hold_s;
        input       hold_d;
        begin
            pick_setting = hold ? {hold_d, hold_s} : {run_d, run_s};
        end
    endfunction

    assign csc_sel = addr_hit(reg_wr, reg_addr);

    // Hold settings apply only once the standstill delay ran out
    assign {act_decay, act_scale} = pick_setting(in_hold_ff,
        run_current_scale_ff, run_mixed_decay_en_ff,
        hold_current_scale_ff, hold_mixed_decay_en_ff);

    assign entry_bus = {entry_b, entry_a};

    generate
        for (ch = 0; ch < NCHAN; ch = ch + 1) begin : g_chan
            // Non-stepper motors pass the raw entry
            assign nxt_scaled_bus[ch*EW +: EW] = motor_is_stepper ?
                scale_entry(entry_bus[ch*EW +: EW], act_scale) :
                entry_bus[ch*EW +: EW];
        end
    endgenerate

    // Write-only settings; no read-back, so a bad write shows only at the outputs
    always @* begin
        nxt_run_scale  = run_current_scale_ff;
        nxt_run_decay  = run_mixed_decay_en_ff;
        nxt_hold_scale = hold_current_scale_ff;
        nxt_hold_decay = hold_mixed_decay_en_ff;
        if (csc_sel) begin
            nxt_run_scale  = clamp_scale(
                reg_wdata[`MCS_RUN_SCALE_MSB:`MCS_RUN_SCALE_LSB]);
            nxt_run_decay  = reg_wdata[`MCS_RUN_DECAY_BIT];
            nxt_hold_scale = clamp_scale(
                reg_wdata[`MCS_HOLD_SCALE_MSB:`MCS_HOLD_SCALE_LSB]);
            nxt_hold_decay = reg_wdata[`MCS_HOLD_DECAY_BIT];
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            run_current_scale_ff   <= `MCS_RUN_SCALE_RST;
            run_mixed_decay_en_ff  <= `MCS_RUN_DECAY_RST;
            hold_current_scale_ff  <= `MCS_HOLD_SCALE_RST;
            hold_mixed_decay_en_ff <= `MCS_HOLD_DECAY_RST;
        end else begin
            run_current_scale_ff   <= nxt_run_scale;
            run_mixed_decay_en_ff  <= nxt_run_decay;
            hold_current_scale_ff  <= nxt_hold_scale;
            hold_mixed_decay_en_ff <= nxt_hold_decay;
        end
    end

    // Standstill timer; motion clears it so the next stop starts afresh
    always @* begin
        nxt_state     = state_ff;
        nxt_still_cnt = still_cnt_ff;
        if (motor_moving) begin
            nxt_state     = ST_RUN;
            nxt_still_cnt = 20'h00000;
        end else begin
            case (state_ff)
                ST_RUN, ST_WAIT: begin
                    if (still_cnt_ff >= hold_delay) begin
                        nxt_state = ST_HOLD;
                    end else begin
                        nxt_state     = ST_WAIT;
                        nxt_still_cnt = still_cnt_ff + 20'h00001;
                    end
                end
                ST_HOLD: begin
                    nxt_state = ST_HOLD;
                end
                default: begin
                    nxt_state     = ST_RUN;
                    nxt_still_cnt = 20'h00000;
                end
            endcase
        end
        nxt_in_hold = (nxt_state == ST_HOLD);
    end

    always @(posedge clk) begin
        if (rst) begin
            state_ff     <= ST_RUN;
            still_cnt_ff <= 20'h00000;
            in_hold_ff   <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            still_cnt_ff <= nxt_still_cnt;
            in_hold_ff   <= nxt_in_hold;
        end
    end

    // Non-stepper motors stay enabled; decay still follows the active setting
    always @* begin
        nxt_mixed_decay  = act_decay;
        nxt_drive_enable = 1'b1;
        if (motor_is_stepper) begin
            nxt_drive_enable = (act_scale != 5'h00);
        end
    end

    // Output stage; entries hold between valid pulses
    always @(posedge clk) begin
        if (rst) begin
            scaled_a_ff     <= 12'h000;
            scaled_b_ff     <= 12'h000;
            scaled_valid_ff <= 1'b0;
            drive_enable_ff <= 1'b0;
            mixed_decay_ff  <= 1'b0;
        end else begin
            scaled_valid_ff <= entry_valid;
            drive_enable_ff <= nxt_drive_enable;
            mixed_decay_ff  <= nxt_mixed_decay;
            if (entry_valid) begin
                scaled_a_ff <= nxt_scaled_bus[EW-1:0];
                scaled_b_ff <= nxt_scaled_bus[2*EW-1:EW];
            end
        end
    end

endmodule // mcs_current_scale

/* File: testbench/mcs_props_properties.sv */
// Port assertions for the current scale block
module mcs_props (input wire clk, rst, reg_wr, motor_moving, motor_is_stepper, entry_valid,
    scaled_valid_ff, drive_enable_ff, mixed_decay_ff, in_hold_ff,
    input wire [6:0] reg_addr, input wire [15:0] reg_wdata);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire w = reg_wr && reg_addr == 7'h55;
    // Write taken while running, no second write on its heels
    sequence wr_s; w && motor_moving ##1 !w && motor_moving; endsequence
    vld_src_a: assert property (scaled_valid_ff |-> $past(entry_valid)) else $error("valid");
    vld_out_a: assert property (entry_valid |=> scaled_valid_ff) else $error("valid");
    step_en_a: assert property (!motor_is_stepper |=> drive_enable_ff) else $error("en");
    zero_off_a: assert property (reg_wdata[4:0] == 5'h0 && motor_is_stepper ##0 wr_s
        ##0 motor_is_stepper |=> !drive_enable_ff) else $error("en");
    run_dec_a: assert property (wr_s |=> mixed_decay_ff == $past(reg_wdata[7], 2))
        else $error("decay");
    hold_exit_a: assert property (motor_moving |=> !in_hold_ff) else $error("hold");
    hold_wait_a: assert property ($rose(in_hold_ff) |-> !$past(motor_moving)
        && !$past(motor_moving, 2)) else $error("hold");
    hold_drop_a: assert property ($fell(in_hold_ff) |-> $past(motor_moving))
        else $error("hold");
endmodule // mcs_props
bind mcs_current_scale mcs_props u_chk (.*);

/* File: testbench/mcs_dac_model.sv */
// Far-side converter model latching scaled codes
module mcs_dac_model (input wire clk, scaled_valid_ff, drive_enable_ff,
    input wire [11:0] scaled_a_ff, output logic [11:0] dac_level);
    // Disabled converter latches zero on each valid; between valids it keeps its last code
    always @(posedge clk) if (scaled_valid_ff) dac_level <= drive_enable_ff ? scaled_a_ff : 12'h0;
endmodule // mcs_dac_model

/* File: testbench/mcs_current_scale_tb_top.sv */
// Self-checking bench for the current scale block
module mcs_current_scale_tb_top;
    timeunit 1ns; timeprecision 1ns;
    logic clk=0, rst=1, reg_wr=0, motor_moving=1, motor_is_stepper=1, entry_valid=0;
    logic [6:0] reg_addr=7'h55; logic [15:0] reg_wdata=16'h0; logic [11:0] entry_a=12'h0;
    logic [11:0] entry_b=12'h0;
    wire [11:0] scaled_a_ff, scaled_b_ff, dac_level;
    wire scaled_valid_ff, drive_enable_ff, mixed_decay_ff, in_hold_ff;
    int miscompares=0, checked=0;
    always #50 clk=~clk;
    mcs_current_scale i_dut (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .hold_delay(20'h5), .motor_moving(motor_moving),
        .motor_is_stepper(motor_is_stepper), .entry_valid(entry_valid), .entry_a(entry_a),
        .entry_b(entry_b), .scaled_a_ff(scaled_a_ff), .scaled_b_ff(scaled_b_ff),
        .scaled_valid_ff(scaled_valid_ff), .drive_enable_ff(drive_enable_ff),
        .mixed_decay_ff(mixed_decay_ff), .in_hold_ff(in_hold_ff));
    mcs_dac_model i_dac (.clk(clk), .scaled_valid_ff(scaled_valid_ff),
        .drive_enable_ff(drive_enable_ff), .scaled_a_ff(scaled_a_ff), .dac_level(dac_level));
    task cyc(int k); repeat (k) @(posedge clk); #1; endtask
    task chk(string n, logic [11:0] g, e); checked++;
        if (g!==e) begin miscompares++; $display("Error %s exp %h got %h", n, e, g); end
    endtask
    task wr(logic [15:0] d, logic [6:0] a=7'h55);
        cyc(1); reg_wr=1; reg_addr=a; reg_wdata=d; cyc(1); reg_wr=0; cyc(1);
    endtask
    task ent(logic [11:0] a); entry_valid=1; entry_a=a; entry_b=a>>1; cyc(1); entry_valid=0;
    endtask
    task report_and_stop; $display("%0d checks, %0d bad", checked, miscompares);
        if (miscompares==0 && checked>0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin #99999 miscompares++; report_and_stop; end
    initial begin
        cyc(12); rst=0; cyc(1); ent(12'hff0);
        chk("a", scaled_a_ff, 12'hff0); chk("md", mixed_decay_ff, 1'h1);
        wr(16'h5); ent(12'h800); chk("a", scaled_a_ff, 12'h280);
        chk("b", scaled_b_ff, 12'h140); chk("v", scaled_valid_ff, 1'h1);
        $display("run done"); wr(16'h80); wr(16'h90, 7'h54); ent(12'h7ff); cyc(1);
        chk("en", drive_enable_ff, 1'h0); chk("dac", dac_level, 12'h0);
        motor_is_stepper=0; ent(12'h123); chk("a", scaled_a_ff, 12'h123);
        $display("off done"); motor_is_stepper=1; wr(16'h8310); motor_moving=0; cyc(5);
        chk("h", in_hold_ff, 1'h0); cyc(1); chk("h", in_hold_ff, 1'h1);
        ent(12'h800); chk("a", scaled_a_ff, 12'h180); chk("md", mixed_decay_ff, 1'h1);
        motor_moving=1; cyc(1); chk("h", in_hold_ff, 1'h0); ent(12'h800);
        chk("a", scaled_a_ff, 12'h800); chk("md", mixed_decay_ff, 1'h0);
        $display("hold done"); report_and_stop;
    end
endmodule // mcs_current_scale_tb_top
